//--- sio_pkg.sv
// Shared constants for both ends of the sensor I/O link
package sio_pkg;
	// Clock and link timing
	localparam int CLK_PERIOD_NS = 5;
	localparam int LINK_PERIOD_NS = 125;
	localparam int LINK_HALF_CYC = (LINK_PERIOD_NS + 2 * CLK_PERIOD_NS - 1) / (2 * CLK_PERIOD_NS);
	// Internal time bases, 0.61035 ms and 18.921 ms
	localparam int TB0_NS = 610350;
	localparam int TB1_NS = 18921000;
	localparam int TB0_CYC = TB0_NS / CLK_PERIOD_NS;
	localparam int TB1_CYC = TB1_NS / CLK_PERIOD_NS;
	// Data-ready pulse, 100 us to 200 us
	localparam int DR_MIN_NS = 100000;
	localparam int DR_MAX_NS = 200000;
	localparam int DR_MIN_CYC = (DR_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int DR_MAX_CYC = DR_MAX_NS / CLK_PERIOD_NS;
	// Link frame layout
	localparam int FRAME_BITS = 16;
	localparam int FRAME_WR = 15;
	// Device register addresses (7-bit link addresses)
	localparam logic [6:0] ADDR_AUX = 7'h30;
	localparam logic [6:0] ADDR_LINE = 7'h32;
	localparam logic [6:0] ADDR_MISC = 7'h34;
	localparam logic [6:0] ADDR_SAMP = 7'h36;
	localparam logic [6:0] ADDR_DIAG = 7'h3c;
	localparam logic [6:0] ADDR_GCMD = 7'h3e;
	// Device reset values and writable bits
	localparam logic [15:0] LINE_RST = 16'h0000;
	localparam logic [15:0] MISC_RST = 16'h0006;
	localparam logic [15:0] AUX_RST = 16'h0000;
	localparam logic [15:0] SAMP_RST = 16'h0001;
	localparam logic [15:0] DIAG_RST = 16'h0000;
	localparam logic [15:0] LINE_WMASK = 16'h0f0f;
	localparam logic [15:0] MISC_WMASK = 16'h0fc7;
	localparam logic [15:0] AUX_WMASK = 16'h0fff;
	localparam logic [15:0] SAMP_WMASK = 16'h00ff;
	// Device field positions
	localparam int LINE_LVL_LSB = 8;
	localparam int EXT_CLK_LINE = 3;
	localparam int MISC_DR_SEL = 0;
	localparam int MISC_DR_POL = 1;
	localparam int MISC_DR_EN = 2;
	localparam int MISC_ORIGIN = 6;
	localparam int MISC_LCOMP = 7;
	localparam int MISC_ST_POS = 8;
	localparam int MISC_ST_NEG = 9;
	localparam int MISC_SELFTEST = 10;
	localparam int MISC_MEMTEST = 11;
	localparam int GCMD_DAC_LATCH = 2;
	localparam int SAMP_TB = 7;
	localparam int DIAG_ST_ERR = 5;
	localparam int DIAG_MEM = 6;
	localparam int DIAG_ST_LSB = 10;
	// Host register byte offsets and fields
	localparam logic [7:0] H_CMD = 8'h00;
	localparam logic [7:0] H_STAT = 8'h04;
	localparam logic [7:0] H_IRQ = 8'h08;
	localparam logic [7:0] H_MASK = 8'h0c;
	localparam logic [7:0] H_GPDRV = 8'h10;
	localparam int STAT_BUSY = 16;
	localparam int STAT_PIN_LSB = 20;
	localparam int IRQ_DONE = 0;
	localparam int IRQ_DRDY = 1;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

//--- sio_link_if.sv
// Link between host and device: SPI wires and four shared general-purpose lines
interface sio_link_if;
	logic cs_n;
	logic sclk;
	logic mosi;
	logic miso;
	logic [3:0] dev_gp_out;
	logic [3:0] dev_gp_oe;
	logic [3:0] host_gp_out;
	logic [3:0] host_gp_oe;
	logic [3:0] gp_line;

	// Wire level; the device wins a clash and an undriven line reads low
	assign gp_line = (dev_gp_oe & dev_gp_out) | (~dev_gp_oe & host_gp_oe & host_gp_out);

	modport dev(input cs_n, input sclk, input mosi, input gp_line, output miso, output dev_gp_out, output dev_gp_oe);
	modport host(output cs_n, output sclk, output mosi, output host_gp_out, output host_gp_oe, input miso,
		input gp_line);
endinterface

//--- sio_host.sv
// Host end: AXI4-Lite register slave driving the SPI master and general-purpose lines
module sio_host import sio_pkg::*; #(
	parameter int HALF_CYC = LINK_HALF_CYC
) (
	input logic aclk,
	input logic aresetn,
	input logic ce,
	input logic [7:0] s_axi_awaddr,
	input logic s_axi_awvalid,
	output logic s_axi_awready,
	input logic [31:0] s_axi_wdata,
	input logic [3:0] s_axi_wstrb,
	input logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input logic s_axi_bready,
	input logic [7:0] s_axi_araddr,
	input logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input logic s_axi_rready,
	output logic irq,
	sio_link_if.host link
);
	typedef enum logic [2:0] {
		SIO_IDLE = 3'b000,
		SIO_LEAD = 3'b001,
		SIO_LOW = 3'b010,
		SIO_HIGH = 3'b011,
		SIO_TAIL = 3'b100,
		SIO_GAP = 3'b101
	} sio_host_st_e;

	typedef struct packed {
		sio_host_st_e st;
		logic [7:0] cnt;
		logic [4:0] bits;
		logic [15:0] sh;
		logic [15:0] rxw;
		logic sclk;
		logic cs_n;
		logic mosi;
		logic [4:0] s1;
		logic [4:0] s2;
		logic [4:0] s3;
		logic [4:0] lvl;
		logic [1:0] irq_st;
		logic [1:0] irq_mask;
		logic [7:0] gp_drv;
		logic awready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
		logic irq;
	} sio_host_s;

	// Miso needs launch, three sync stages and margin inside one half period
	if (HALF_CYC < 10 || HALF_CYC > 255) begin : g_bad_half
		$error("HALF_CYC out of range");
	end

	localparam logic [7:0] HALF_M1 = 8'(HALF_CYC - 1);

	sio_host_s r;
	sio_host_s n;
	logic [31:0] wmask;
	logic [1:0] irq_clr;
	logic [1:0] irq_ev;

	// Next state: bus slave, SPI sequencer, pin sampling and interrupt
	always_comb begin
		n = r;
		wmask = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}}, {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
		irq_clr = 2'h0;
		irq_ev = 2'h0;
		// Pin inputs: miso at bit 0, lines at 4:1; a change counts when stages two and three agree
		n.s1 = {link.gp_line, link.miso};
		n.s2 = r.s1;
		n.s3 = r.s2;
		n.lvl = (r.s2 & r.s3) | (r.lvl & (r.s2 | r.s3));
		irq_ev[IRQ_DRDY] = n.lvl[1] & ~r.lvl[1];
		// Frame sequencer; each frame is one byte write or one read request
		case (r.st)
			SIO_IDLE: begin
				n.sclk = 1'b1;
				n.cs_n = 1'b1;
			end
			SIO_LEAD: begin
				if (r.cnt == 8'h00) begin
					n.sclk = 1'b0;
					n.mosi = r.sh[FRAME_BITS-1];
					n.sh = {r.sh[14:0], 1'b0};
					n.cnt = HALF_M1;
					n.st = SIO_LOW;
				end else begin
					n.cnt = r.cnt - 8'h01;
				end
			end
			SIO_LOW: begin
				if (r.cnt == 8'h00) begin
					n.sclk = 1'b1;
					n.rxw = {r.rxw[14:0], r.lvl[0]};
					n.bits = r.bits + 5'h01;
					n.cnt = HALF_M1;
					n.st = SIO_HIGH;
				end else begin
					n.cnt = r.cnt - 8'h01;
				end
			end
			SIO_HIGH: begin
				if (r.cnt != 8'h00) begin
					n.cnt = r.cnt - 8'h01;
				end else if (r.bits == 5'(FRAME_BITS)) begin
					n.cnt = HALF_M1;
					n.st = SIO_TAIL;
				end else begin
					n.sclk = 1'b0;
					n.mosi = r.sh[FRAME_BITS-1];
					n.sh = {r.sh[14:0], 1'b0};
					n.cnt = HALF_M1;
					n.st = SIO_LOW;
				end
			end
			SIO_TAIL: begin
				if (r.cnt == 8'h00) begin
					n.cs_n = 1'b1;
					n.cnt = 8'(2 * HALF_CYC - 1);
					n.st = SIO_GAP;
					irq_ev[IRQ_DONE] = 1'b1;
				end else begin
					n.cnt = r.cnt - 8'h01;
				end
			end
			SIO_GAP: begin
				// Gap lets the device finish the frame before the next one opens
				if (r.cnt == 8'h00) begin
					n.st = SIO_IDLE;
				end else begin
					n.cnt = r.cnt - 8'h01;
				end
			end
			default: begin
				n.st = SIO_IDLE;
			end
		endcase
		// Write channel: take address and data together, answer one cycle later
		if (r.awready) begin
			n.awready = 1'b0;
			n.bvalid = 1'b1;
			n.bresp = RESP_OKAY;
			case (s_axi_awaddr)
				H_CMD: begin
					// Refused while a frame is in flight; software polls the busy bit
					if (r.st == SIO_IDLE && s_axi_wstrb[1:0] == 2'h3) begin
						n.sh = s_axi_wdata[15:0];
						n.cs_n = 1'b0;
						n.bits = 5'h00;
						n.cnt = HALF_M1;
						n.st = SIO_LEAD;
					end
				end
				H_STAT: begin
				end
				H_IRQ: irq_clr = s_axi_wdata[1:0] & wmask[1:0];
				H_MASK: n.irq_mask = (r.irq_mask & ~wmask[1:0]) | (s_axi_wdata[1:0] & wmask[1:0]);
				H_GPDRV: n.gp_drv = (r.gp_drv & ~wmask[7:0]) | (s_axi_wdata[7:0] & wmask[7:0]);
				default: n.bresp = RESP_SLVERR;
			endcase
		end else if (!r.bvalid && s_axi_awvalid && s_axi_wvalid) begin
			n.awready = 1'b1;
		end
		if (r.bvalid && s_axi_bready) begin
			n.bvalid = 1'b0;
		end
		// Read channel
		if (r.arready) begin
			n.arready = 1'b0;
			n.rvalid = 1'b1;
			n.rresp = RESP_OKAY;
			n.rdata = 32'h0;
			case (s_axi_araddr)
				H_CMD: n.rdata = 32'h0;
				H_STAT: begin
					n.rdata[15:0] = r.rxw;
					n.rdata[STAT_BUSY] = (r.st != SIO_IDLE);
					n.rdata[STAT_PIN_LSB+:4] = r.lvl[4:1];
				end
				H_IRQ: n.rdata[1:0] = r.irq_st;
				H_MASK: n.rdata[1:0] = r.irq_mask;
				H_GPDRV: n.rdata[7:0] = r.gp_drv;
				default: n.rresp = RESP_SLVERR;
			endcase
		end else if (!r.rvalid && s_axi_arvalid) begin
			n.arready = 1'b1;
		end
		if (r.rvalid && s_axi_rready) begin
			n.rvalid = 1'b0;
		end
		// Sticky events: a set in the clearing cycle survives
		n.irq_st = (r.irq_st & ~irq_clr) | irq_ev;
		n.irq = |(n.irq_st & n.irq_mask);
	end

	// State register; clock enable freezes everything
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			r <= '0;
			r.st <= SIO_IDLE;
			r.sclk <= 1'b1;
			r.cs_n <= 1'b1;
			r.s1 <= 5'h01;
			r.s2 <= 5'h01;
			r.s3 <= 5'h01;
			r.lvl <= 5'h01;
		end else if (ce) begin
			r <= n;
		end
	end

	assign s_axi_awready = r.awready;
	assign s_axi_wready = r.awready;
	assign s_axi_bvalid = r.bvalid;
	assign s_axi_bresp = r.bresp;
	assign s_axi_arready = r.arready;
	assign s_axi_rvalid = r.rvalid;
	assign s_axi_rresp = r.rresp;
	assign s_axi_rdata = r.rdata;
	assign irq = r.irq;
	assign link.cs_n = r.cs_n;
	assign link.sclk = r.sclk;
	assign link.mosi = r.mosi;
	assign link.host_gp_out = r.gp_drv[3:0];
	assign link.host_gp_oe = r.gp_drv[7:4];
endmodule

//--- sio_device.sv
// Device end: SPI register slave, general-purpose lines, data-ready pacing and test triggers
// Summary of operation
// - Line owner: data-ready, then alarm, then config
// - Config bits 3:0 set line directions
// - Config bits 11:8 hold line levels
// - Line 4 input plus zero period: external sampling
// - Reset: data-ready on line 1, active high
// - Misc bits 2:0: enable, polarity, line
// - Data-ready pulse lasts 100 to 200 us
// - Misc bit 11 runs memory check, self-clears
// - Misc bit 10 runs self-test, posts flags
// - Misc bits 9, 8 hold manual stimulus
// - Misc bits 7, 6 enable compensations
// - Twelve-bit converter code in holding register
// - Global command bit 2 latches both bytes
// - Host writes low byte, then high byte
// - Host waits about 50 ms after changes
//
// The register addresses and register access over AXI4-Lite were left to the implementer.
module sio_device import sio_pkg::*; #(
	parameter int TB0_CYCLES = TB0_CYC,
	parameter int TB1_CYCLES = TB1_CYC,
	parameter int DR_CYCLES = DR_MIN_CYC
) (
	input logic aclk,
	input logic aresetn,
	input logic ce,
	sio_link_if.dev link,
	input logic alarm_claim,
	input logic alarm_line_sel,
	input logic alarm_level,
	input logic st_done,
	input logic [5:0] st_fail,
	input logic mt_done,
	input logic mt_fail,
	output logic st_start,
	output logic mt_start,
	output logic st_neg,
	output logic st_pos,
	output logic lin_comp_en,
	output logic origin_align_en,
	output logic [11:0] dac_code,
	output logic sample_tick
);
	// Synchroniser bit positions
	localparam int PIN_CS = 0;
	localparam int PIN_SCLK = 1;
	localparam int PIN_MOSI = 2;
	localparam int PIN_GP = 3;
	localparam logic [6:0] PIN_IDLE = 7'h03;

	typedef struct packed {
		logic [6:0] s1;
		logic [6:0] s2;
		logic [6:0] s3;
		logic [6:0] lvl;
		logic [15:0] line_cfg;
		logic [15:0] misc;
		logic [15:0] aux;
		logic [15:0] samp;
		logic [15:0] diag;
		logic [11:0] dac;
		logic [15:0] rx;
		logic [15:0] tx;
		logic [4:0] bitcnt;
		logic [23:0] tb_cnt;
		logic [6:0] tb_mult;
		logic [23:0] dr_cnt;
		logic [3:0] gp_out;
		logic [3:0] gp_oe;
		logic miso;
		logic tick;
		logic st_start;
		logic mt_start;
	} sio_dev_s;

	if (DR_CYCLES < DR_MIN_CYC || DR_CYCLES > DR_MAX_CYC || TB0_CYCLES < 1 || TB1_CYCLES < 1
		|| TB0_CYCLES >= 2 ** 24 || TB1_CYCLES >= 2 ** 24) begin : g_bad_param
		$error("Time base or pulse length out of range");
	end

	sio_dev_s r;
	sio_dev_s n;
	logic cs_rise;
	logic cs_fall;
	logic sclk_rise;
	logic sclk_fall;
	logic gp4_rise;
	logic ext_mode;
	logic frame_ok;
	logic [6:0] fa;
	logic [7:0] fd;
	logic [23:0] base_m1;
	logic [15:0] line_rd;
	logic dr_level;
	logic [15:0] wr_new;

	// Byte write into a 16-bit register; odd address takes the high byte
	function automatic logic [15:0] wr_byte(input logic [15:0] old, input logic [15:0] wmask, input logic hi,
		input logic [7:0] d);
		logic [15:0] lane;
		lane = (hi ? 16'hff00 : 16'h00ff) & wmask;
		return (old & ~lane) | ({d, d} & lane);
	endfunction

	// Next state of the whole device end
	always_comb begin
		n = r;
		n.tick = 1'b0;
		n.st_start = 1'b0;
		n.mt_start = 1'b0;
		wr_new = 16'h0000;
		// Pin inputs; a change counts once stages two and three agree
		n.s1 = {link.gp_line, link.mosi, link.sclk, link.cs_n};
		n.s2 = r.s1;
		n.s3 = r.s2;
		n.lvl = (r.s2 & r.s3) | (r.lvl & (r.s2 | r.s3));
		cs_rise = n.lvl[PIN_CS] & ~r.lvl[PIN_CS];
		cs_fall = ~n.lvl[PIN_CS] & r.lvl[PIN_CS];
		sclk_rise = n.lvl[PIN_SCLK] & ~r.lvl[PIN_SCLK];
		sclk_fall = ~n.lvl[PIN_SCLK] & r.lvl[PIN_SCLK];
		gp4_rise = n.lvl[PIN_GP+EXT_CLK_LINE] & ~r.lvl[PIN_GP+EXT_CLK_LINE];
		// Inputs shown for input lines, written value for output lines
		line_rd = {4'h0, (r.line_cfg[3:0] & r.line_cfg[11:8]) | (~r.line_cfg[3:0] & r.lvl[PIN_GP+:4]),
			4'h0, r.line_cfg[3:0]};
		// Sample pacing: internal time base, or line 4 rising edges
		ext_mode = ~r.line_cfg[EXT_CLK_LINE] && r.samp[7:0] == 8'h00;
		base_m1 = r.samp[SAMP_TB] ? 24'(TB1_CYCLES - 1) : 24'(TB0_CYCLES - 1);
		if (ext_mode) begin
			n.tb_cnt = 24'h0;
			n.tb_mult = 7'h0;
			n.tick = gp4_rise;
		end else if (r.tb_cnt >= base_m1) begin
			n.tb_cnt = 24'h0;
			if (r.tb_mult >= r.samp[6:0]) begin
				n.tb_mult = 7'h0;
				n.tick = 1'b1;
			end else begin
				n.tb_mult = r.tb_mult + 7'h01;
			end
		end else begin
			n.tb_cnt = r.tb_cnt + 24'h1;
		end
		// Data-ready pulse; a tick during a pulse is dropped so the width never stretches
		if (r.dr_cnt != 24'h0) begin
			n.dr_cnt = r.dr_cnt - 24'h1;
		end else if (n.tick) begin
			n.dr_cnt = 24'(DR_CYCLES);
		end
		dr_level = r.misc[MISC_DR_POL] ? (n.dr_cnt != 24'h0) : (n.dr_cnt == 24'h0);
		// Test completion returns the trigger bits to zero
		if (st_done) begin
			n.misc[MISC_SELFTEST] = 1'b0;
		end
		if (mt_done) begin
			n.misc[MISC_MEMTEST] = 1'b0;
		end
		// Link shifter: both ends launch on the falling edge and sample on the rising edge
		if (cs_fall) begin
			n.bitcnt = 5'h00;
		end
		if (!n.lvl[PIN_CS]) begin
			if (sclk_rise && r.bitcnt != 5'(FRAME_BITS)) begin
				n.rx = {r.rx[14:0], r.lvl[PIN_MOSI]};
				n.bitcnt = r.bitcnt + 5'h01;
			end
			if (sclk_fall) begin
				n.miso = r.tx[FRAME_BITS-1];
				n.tx = {r.tx[14:0], 1'b0};
			end
		end
		// Frame end: short frames are dropped whole
		frame_ok = cs_rise && r.bitcnt == 5'(FRAME_BITS);
		fa = r.rx[14:8];
		fd = r.rx[7:0];
		if (frame_ok && r.rx[FRAME_WR]) begin
			n.tx = 16'h0000;
			case ({fa[6:1], 1'b0})
				ADDR_LINE: n.line_cfg = wr_byte(r.line_cfg, LINE_WMASK, fa[0], fd);
				ADDR_AUX: n.aux = wr_byte(r.aux, AUX_WMASK, fa[0], fd);
				ADDR_SAMP: n.samp = wr_byte(r.samp, SAMP_WMASK, fa[0], fd);
				ADDR_MISC: begin
					wr_new = wr_byte(r.misc, MISC_WMASK, fa[0], fd);
					n.misc = wr_new;
					// Host set wins over a completion in the same cycle
					n.st_start = wr_new[MISC_SELFTEST] & ~r.misc[MISC_SELFTEST];
					n.mt_start = wr_new[MISC_MEMTEST] & ~r.misc[MISC_MEMTEST];
				end
				ADDR_GCMD: begin
					// Only the latch strobe moves the code, so byte writes never glitch the output
					if (!fa[0] && fd[GCMD_DAC_LATCH]) begin
						n.dac = r.aux[11:0];
					end
				end
				default: begin
				end
			endcase
		end else if (frame_ok) begin
			// Read answer is shifted out during the next frame
			case ({fa[6:1], 1'b0})
				ADDR_LINE: n.tx = line_rd;
				ADDR_AUX: n.tx = r.aux;
				ADDR_SAMP: n.tx = r.samp;
				ADDR_MISC: n.tx = r.misc;
				ADDR_DIAG: begin
					n.tx = r.diag;
					n.diag = DIAG_RST;
				end
				default: n.tx = 16'h0000;
			endcase
		end
		// Results posted after the read clear, so a fresh result is never lost
		if (st_done && r.misc[MISC_SELFTEST]) begin
			n.diag[DIAG_ST_LSB+:6] = n.diag[DIAG_ST_LSB+:6] | st_fail;
			n.diag[DIAG_ST_ERR] = n.diag[DIAG_ST_ERR] | (|st_fail);
		end
		if (mt_done && r.misc[MISC_MEMTEST]) begin
			n.diag[DIAG_MEM] = n.diag[DIAG_MEM] | mt_fail;
		end
		// Line ownership, highest claim first; config returns when a claim drops
		for (int i = 0; i < 4; i++) begin
			if (i < 2 && n.misc[MISC_DR_EN] && n.misc[MISC_DR_SEL] == (i == 1)) begin
				n.gp_oe[i] = 1'b1;
				n.gp_out[i] = dr_level;
			end else if (i < 2 && alarm_claim && alarm_line_sel == (i == 1)) begin
				n.gp_oe[i] = 1'b1;
				n.gp_out[i] = alarm_level;
			end else begin
				n.gp_oe[i] = n.line_cfg[i];
				n.gp_out[i] = n.line_cfg[LINE_LVL_LSB+i];
			end
		end
	end

	// State register; clock enable freezes everything
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			r <= '0;
			r.s1 <= PIN_IDLE;
			r.s2 <= PIN_IDLE;
			r.s3 <= PIN_IDLE;
			r.lvl <= PIN_IDLE;
			r.line_cfg <= LINE_RST;
			r.misc <= MISC_RST;
			r.aux <= AUX_RST;
			r.samp <= SAMP_RST;
			r.diag <= DIAG_RST;
			r.gp_oe <= 4'h1;
		end else if (ce) begin
			r <= n;
		end
	end

	assign link.miso = r.miso;
	assign link.dev_gp_out = r.gp_out;
	assign link.dev_gp_oe = r.gp_oe;
	assign st_start = r.st_start;
	assign mt_start = r.mt_start;
	assign st_neg = r.misc[MISC_ST_NEG];
	assign st_pos = r.misc[MISC_ST_POS];
	assign lin_comp_en = r.misc[MISC_LCOMP];
	assign origin_align_en = r.misc[MISC_ORIGIN];
	assign dac_code = r.dac;
	assign sample_tick = r.tick;
endmodule

//--- sio_assertions.sv
// Checker of link framing and line 1 data-ready pulse width on the shared wires
module sio_assertions import sio_pkg::*; (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic mosi,
	input wire logic miso,
	input wire logic [3:0] dev_gp_out,
	input wire logic [3:0] dev_gp_oe
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	logic sclk_q;
	logic [4:0] rises;
	logic [17:0] hi;
	// Clock rises per frame, and cycles line 1 stays driven high; a short frame shows at cs_n rise
	always_ff @(posedge aclk) begin
		sclk_q <= sclk;
		rises <= (!aresetn || cs_n) ? 5'h00 : rises + {4'h0, sclk & ~sclk_q};
		hi <= (aresetn && dev_gp_oe[0] && dev_gp_out[0]) ? hi + 18'h1 : 18'h0;
	end
	a_sclk_idle_high: assert property (cs_n |-> sclk)
		else $error("link clock low outside a frame");
	a_mosi_steady_rise: assert property ($rose(sclk) |-> $stable(mosi))
		else $error("mosi moved at a clock rise");
	a_miso_steady_rise: assert property ($rose(sclk) && !cs_n |-> $stable(miso))
		else $error("miso moved at a clock rise");
	a_frame_bit_count: assert property ($rose(cs_n) |-> rises == 5'h10)
		else $error("frame without sixteen clock rises");
	a_frame_lead_time: assert property ($fell(cs_n) |-> sclk [*8])
		else $error("clock started too soon after select");
	a_frame_gap_time: assert property ($rose(cs_n) |=> cs_n [*8])
		else $error("frames too close");
	a_reset_drdy_idle: assert property ($rose(aresetn) |-> dev_gp_oe == 4'h1 && dev_gp_out == 4'h0)
		else $error("line 1 not idle data-ready after reset");
	a_drdy_pulse_width: assert property ($fell(dev_gp_out[0]) && dev_gp_oe[0] |-> hi >= DR_MIN_CYC && hi <= DR_MAX_CYC)
		else $error("data-ready pulse width out of range");
	// Main scenarios reached
	c_frame_end: cover property ($rose(cs_n));
	c_drdy_line1: cover property ($fell(dev_gp_out[0]) && dev_gp_oe[0]);
	c_line2_high: cover property (dev_gp_oe[1] && dev_gp_out[1]);
endmodule

//--- sio_test.sv
// Bench for the host and device ends joined over the link
module sio_test import sio_pkg::*; ();
	timeunit 1ns;
	timeprecision 100ps;
	logic aclk = 1'b0, aresetn = 1'b0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, rdat, rdata;
	logic [1:0] rrsp, wrsp, bresp, rresp;
	logic awready, wready, bvalid, arready, rvalid, irq;
	logic claim = 1'b0, sel = 1'b0, lvl = 1'b0, st_done = 1'b0, mt_done = 1'b0, mt_fail = 1'b0;
	logic [5:0] st_fail = 6'h00;
	logic st_start, mt_start, st_neg, st_pos, lcomp, origin, tick;
	logic [11:0] dac;
	int err_total = 0, samples_checked = 0, n_st = 0, n_mt = 0, n_tick = 0;
	sio_link_if link();
	sio_host i_sio_host(.aclk(aclk), .aresetn(aresetn), .ce(1'b1), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .irq(irq), .link(link));
	// Slow internal time base keeps ticks under the bench's control via line 4
	sio_device #(.TB0_CYCLES(60000), .DR_CYCLES(25000)) i_sio_device(.aclk(aclk), .aresetn(aresetn), .ce(1'b1),
		.link(link), .alarm_claim(claim), .alarm_line_sel(sel), .alarm_level(lvl), .st_done(st_done),
		.st_fail(st_fail), .mt_done(mt_done), .mt_fail(mt_fail), .st_start(st_start), .mt_start(mt_start),
		.st_neg(st_neg), .st_pos(st_pos), .lin_comp_en(lcomp), .origin_align_en(origin), .dac_code(dac),
		.sample_tick(tick));
	sio_assertions i_sio_assertions(.aclk(aclk), .aresetn(aresetn), .cs_n(link.cs_n), .sclk(link.sclk),
		.mosi(link.mosi), .miso(link.miso), .dev_gp_out(link.dev_gp_out), .dev_gp_oe(link.dev_gp_oe));
	always #2.5 aclk = ~aclk;
	// Count one-cycle pulses from the device
	always @(posedge aclk) begin
		n_st += int'(st_start === 1'b1);
		n_mt += int'(mt_start === 1'b1);
		n_tick += int'(tick === 1'b1);
	end
	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		samples_checked++;
		if (s !== e) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", nm, e, s);
		end
	endtask
	// Write one word; each channel is released at the edge it is taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic aw_ok = 1'b0, w_ok = 1'b0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(aw_ok && w_ok)) begin
			@(posedge aclk);
			if (awready === 1'b1) begin
				aw_ok = 1'b1;
				awvalid <= 1'b0;
			end
			if (wready === 1'b1) begin
				w_ok = 1'b1;
				wvalid <= 1'b0;
			end
		end
		do @(posedge aclk); while (bvalid !== 1'b1);
		wrsp = bresp;
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge aclk); while (rvalid !== 1'b1);
		rdat = rdata;
		rrsp = rresp;
		rready <= 1'b0;
	endtask
	// One link frame; returns eight cycles after busy clears, leaving the received word in rdat
	task automatic frame(input logic [15:0] w);
		wr(H_CMD, {16'h0, w});
		do rd(H_STAT); while (rdat[STAT_BUSY] !== 1'b0);
		repeat (8) @(posedge aclk);
	endtask
	task automatic dev_wr(input logic [6:0] a, input logic [7:0] d);
		frame({1'b1, a, d});
	endtask
	// The answer to a read frame arrives during the next frame
	task automatic dev_rd(input logic [6:0] a);
		frame({1'b0, a, 8'h00});
		frame({1'b0, a, 8'h00});
	endtask
	// Wait for a data-ready pulse on line i and measure it
	task automatic pw(input int i);
		int n = 0;
		while (link.gp_line[i] !== 1'b1 && n < 300) begin
			@(posedge aclk);
			n++;
		end
		n = 0;
		while (link.gp_line[i] === 1'b1 && n < 50000) begin
			@(posedge aclk);
			n++;
		end
		chk("drdy width", 32'(n >= DR_MIN_CYC && n <= DR_MAX_CYC), 32'h1);
	endtask
	task automatic test_done();
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	// Watchdog above the expected run of about 70000 cycles, still inside the run budget
	initial begin
		repeat (95000) @(posedge aclk);
		err_total++;
		$display("ERROR watchdog expected finish seen timeout");
		test_done();
	end
	initial begin
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		chk("line oe", link.dev_gp_oe, 4'h1);
		dev_rd(ADDR_MISC);
		chk("misc rst", rdat[15:0], 16'h0006);
		dev_rd(ADDR_LINE);
		chk("line rst", rdat[15:0], 16'h0000);
		dev_rd(ADDR_AUX);
		chk("aux rst", rdat[15:0], 16'h0000);
		rd(H_IRQ);
		chk("done flag", rdat[IRQ_DONE], 1'b1);
		chk("irq masked", irq, 1'b0);
		wr(H_MASK, 32'h1);
		repeat (2) @(posedge aclk);
		chk("irq set", irq, 1'b1);
		wr(H_IRQ, 32'h1);
		repeat (2) @(posedge aclk);
		chk("irq clr", irq, 1'b0);
		rd(8'h40);
		chk("unmapped", rrsp, RESP_SLVERR);
		wr(8'h40, 32'h0);
		chk("wr unmapped", wrsp, RESP_SLVERR);
		$display("test reset done");
		// Byte writes alone leave the converter untouched
		dev_wr(ADDR_AUX, 8'hd9);
		dev_wr(ADDR_AUX + 7'h01, 8'h04);
		chk("dac held", dac, 12'h000);
		dev_rd(ADDR_AUX);
		chk("aux", rdat[15:0], 16'h04d9);
		dev_wr(ADDR_GCMD, 8'h04);
		chk("dac latch", dac, 12'h4d9);
		dev_wr(ADDR_AUX + 7'h01, 8'hff);
		dev_rd(ADDR_AUX);
		chk("aux mask", rdat[15:0], 16'h0fd9);
		chk("dac kept", dac, 12'h4d9);
		$display("test converter done");
		dev_wr(ADDR_LINE + 7'h01, 8'h08);
		dev_wr(ADDR_LINE, 8'h0c);
		wr(H_GPDRV, 32'h22);
		dev_rd(ADDR_LINE);
		chk("line cfg", rdat[15:0], 16'h0a0c);
		chk("out lvl", link.gp_line[3:2], 2'b10);
		chk("dir", link.dev_gp_oe[3:2], 2'b11);
		$display("test lines done");
		// Alarm loses to data-ready on line 1, beats config on line 2
		claim <= 1'b1;
		lvl <= 1'b1;
		repeat (4) @(posedge aclk);
		chk("l1 drdy", link.gp_line[0], 1'b0);
		sel <= 1'b1;
		lvl <= 1'b0;
		repeat (4) @(posedge aclk);
		chk("l2 alarm", {link.dev_gp_oe[1], link.gp_line[1]}, 2'b10);
		claim <= 1'b0;
		repeat (4) @(posedge aclk);
		chk("l2 back", link.gp_line[1], 1'b1);
		$display("test priority done");
		dev_wr(ADDR_MISC, 8'hc6);
		chk("comp", {lcomp, origin}, 2'b11);
		dev_wr(ADDR_MISC + 7'h01, 8'h03);
		// Settle after a stimulus change; no sensor chain here, so a short wait stands in
		repeat (100) @(posedge aclk);
		chk("stim", {st_neg, st_pos}, 2'b11);
		dev_rd(ADDR_MISC);
		chk("misc", rdat[15:0], 16'h03c6);
		dev_wr(ADDR_MISC + 7'h01, 8'h04);
		chk("st start", n_st, 1);
		chk("stim off", {st_neg, st_pos}, 2'b00);
		st_fail <= 6'h21;
		st_done <= 1'b1;
		@(posedge aclk);
		st_done <= 1'b0;
		dev_rd(ADDR_MISC);
		chk("st clr", rdat[15:0], 16'h00c6);
		dev_rd(ADDR_DIAG);
		chk("st flags", rdat[15:0], 16'h8420);
		dev_rd(ADDR_DIAG);
		chk("flags clr", rdat[15:0], 16'h0000);
		dev_wr(ADDR_MISC + 7'h01, 8'h08);
		chk("mt start", n_mt, 1);
		mt_fail <= 1'b1;
		mt_done <= 1'b1;
		@(posedge aclk);
		mt_done <= 1'b0;
		dev_rd(ADDR_MISC);
		chk("mt clr", rdat[15:0], 16'h00c6);
		dev_rd(ADDR_DIAG);
		chk("mt flag", rdat[15:0], 16'h0040);
		$display("test triggers done");
		// Line 4 input plus zero period: host edges on line 4 pace the pulses
		dev_wr(ADDR_LINE, 8'h04);
		wr(H_GPDRV, 32'h80);
		dev_wr(ADDR_SAMP, 8'h00);
		wr(H_GPDRV, 32'h88);
		pw(0);
		chk("ticks", n_tick, 1);
		dev_wr(ADDR_MISC, 8'hc7);
		chk("l1 freed", link.dev_gp_oe[0], 1'b0);
		wr(H_GPDRV, 32'h80);
		wr(H_GPDRV, 32'h88);
		pw(1);
		chk("ticks", n_tick, 2);
		dev_wr(ADDR_MISC, 8'hc4);
		chk("low pol idle", link.gp_line[0], 1'b1);
		chk("l2 freed", link.dev_gp_oe[1], 1'b0);
		$display("test data-ready done");
		test_done();
	end
endmodule
